// ===== core/cphio_pkg.sv
package cphio_pkg;
  localparam int WORD_W = 16;
  localparam int BUS_W  = 6;
  localparam int LINE_W = 4;
  localparam int FC_W   = 6;
  localparam int LINES  = 16;
  // channel_function_word layout, bit 0 is the lsb
  localparam int BUS_LSB  = 10;
  localparam int LINE_LSB = 6;
  // operation_code_field values
  localparam logic [5:0] FC_RANGE  = 6'h0c;
  localparam logic [5:0] FC_STAT   = 6'h18;
  localparam logic [5:0] FC_NEXT   = 6'h1a;
  localparam logic [5:0] FC_LR5    = 6'h1c;
  localparam logic [5:0] FC_LCT_RD = 6'h1e;
  localparam logic [5:0] FC_ID     = 6'h26;
  localparam logic [5:0] FC_LCT_WR = 6'h0b;
  // line_control_table, init and timeout cycle counts
  localparam int         LCT_BYTES = 64;
  localparam logic [5:0] LCT_INDEX = 6'h37;
  localparam logic [7:0] INIT_CYCLES = 8'h10;
  localparam logic [3:0] TMO_CYCLES  = 4'h8;
  // host register map and status bits
  localparam logic [1:0] REG_CMD    = 2'h0;
  localparam logic [1:0] REG_OPND   = 2'h1;
  localparam logic [1:0] REG_RESULT = 2'h2;
  localparam logic [1:0] REG_STATUS = 2'h3;
  localparam int ST_BUSY = 0;
  localparam int ST_ACC  = 1;
  localparam int ST_NAK  = 2;
  localparam int ST_TMO  = 3;
  localparam int ST_IRQ  = 4;
  localparam int ST_LINE = 8;

  function automatic logic [BUS_W-1:0] cfw_bus(input logic [WORD_W-1:0] w);
    return w[BUS_LSB +: BUS_W];
  endfunction

  function automatic logic [LINE_W-1:0] cfw_line(input logic [WORD_W-1:0] w);
    return w[LINE_LSB +: LINE_W];
  endfunction

  function automatic logic [FC_W-1:0] cfw_fc(input logic [WORD_W-1:0] w);
    return w[FC_W-1:0];
  endfunction
endpackage

// ===== core/cphio_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cphio_if;
  logic        req;
  logic [15:0] cfw;
  logic [15:0] wr_opnd;
  logic        rsp;
  logic        acc;
  logic        nak;
  logic [15:0] rd_opnd;
  logic        irq;
  logic [3:0]  irq_line;

  modport dev  (input req, cfw, wr_opnd, output rsp, acc, nak, rd_opnd, irq, irq_line);
  modport host (output req, cfw, wr_opnd, input rsp, acc, nak, rd_opnd, irq, irq_line);
endinterface
`default_nettype wire

// ===== core/cphio_ccb_list.sv
`timescale 1ns/1ps
`default_nettype none
module cphio_ccb_list #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // list access from the decoder
  input  wire logic        clear_i,
  input  wire logic [3:0]  sel_line_i,
  input  wire logic        adv_i,
  output logic      [15:0] head_range_o,
  output logic      [15:0] head_status_o,
  output logic      [15:0] next_status_o,
  output logic             next_valid_o,
  // block setup and completion
  input  wire logic        load_i,
  input  wire logic [3:0]  load_line_i,
  input  wire logic [$clog2(DEPTH)-1:0] load_slot_i,
  input  wire logic [15:0] load_range_i,
  input  wire logic        load_ien_i,
  input  wire logic        cmpl_i,
  input  wire logic [3:0]  cmpl_line_i,
  input  wire logic [$clog2(DEPTH)-1:0] cmpl_slot_i,
  input  wire logic [15:0] cmpl_status_i,
  // completion interrupt
  output logic             irq_o,
  output logic      [3:0]  irq_line_o
);
  localparam int SW = $clog2(DEPTH);
  localparam int N  = cphio_pkg::LINES * DEPTH;

  if (DEPTH < 2 || DEPTH > 64)
  begin
    $error("cphio_ccb_list: DEPTH out of range");
  end

  typedef struct packed {
    logic [N-1:0][15:0]                 range;
    logic [N-1:0][15:0]                 stat;
    logic [N-1:0]                       valid;
    logic [N-1:0]                       done;
    logic [N-1:0]                       ien;
    logic [cphio_pkg::LINES-1:0][SW-1:0] ptr;
    logic                               irq;
    logic [3:0]                         irq_line;
  } cphio_ccb_t;

  cphio_ccb_t r_reg;
  cphio_ccb_t r_next;

  function automatic int idx(input logic [3:0] l, input logic [SW-1:0] s);
    return int'(l) * DEPTH + int'(s);
  endfunction

  function automatic logic [SW-1:0] next_slot(input logic [SW-1:0] s);
    return (int'(s) == DEPTH - 1) ? '0 : SW'(int'(s) + 1);
  endfunction

  logic [SW-1:0] head_slot;
  int            h;
  int            nx;

  assign head_slot     = r_reg.ptr[sel_line_i];
  assign h             = idx(sel_line_i, head_slot);
  assign nx            = idx(sel_line_i, next_slot(head_slot));
  assign head_range_o  = r_reg.range[h];
  assign head_status_o = r_reg.done[h] ? r_reg.stat[h] : 16'h0000;
  assign next_status_o = r_reg.done[nx] ? r_reg.stat[nx] : 16'h0000;
  assign next_valid_o  = r_reg.valid[nx];
  assign irq_o         = r_reg.irq;
  assign irq_line_o    = r_reg.irq_line;

  always_comb
  begin
    int k;
    k = 0;
    r_next = r_reg;
    r_next.irq = 1'b0;
    if (clear_i)
    begin
      r_next.valid = '0;
      r_next.done  = '0;
      r_next.ien   = '0;
      r_next.ptr   = '0;
    end
    else
    begin
      if (adv_i)
      begin
        // old head freed whether or not it completed
        r_next.valid[h] = 1'b0;
        r_next.done[h]  = 1'b0;
        r_next.stat[h]  = 16'h0000;
        r_next.ptr[sel_line_i] = next_slot(head_slot);
      end
      if (load_i)
      begin
        k = idx(load_line_i, load_slot_i);
        r_next.range[k] = load_range_i;
        r_next.ien[k]   = load_ien_i;
        r_next.valid[k] = 1'b1;
        r_next.done[k]  = 1'b0;
        r_next.stat[k]  = 16'h0000;
      end
      // completion applied last so it wins over a same-cycle free
      if (cmpl_i)
      begin
        k = idx(cmpl_line_i, cmpl_slot_i);
        r_next.stat[k] = cmpl_status_i;
        r_next.done[k] = 1'b1;
        if (r_next.ien[k])
        begin
          r_next.irq      = 1'b1;
          r_next.irq_line = cmpl_line_i;
        end
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end
endmodule
`default_nettype wire

// ===== core/cphio_dev.sv
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cphio_dev #(
  parameter logic [5:0] BUS_CHAN = 6'h00,
  parameter int         DEPTH    = 8
) (
  // clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_n_i,
  // host side
  cphio_if.dev                      bus,
  // adapter side
  input  wire logic                 init_req_i,
  input  wire logic [15:0]          adapter_present_i,
  input  wire logic [15:0][15:0]    lr5_i,
  input  wire logic [15:0][15:0]    adapter_id_i,
  // block setup and completion
  input  wire logic                 ccb_load_i,
  input  wire logic [3:0]           ccb_load_line_i,
  input  wire logic [$clog2(DEPTH)-1:0] ccb_load_slot_i,
  input  wire logic [15:0]          ccb_load_range_i,
  input  wire logic                 ccb_load_ien_i,
  input  wire logic                 ccb_cmpl_i,
  input  wire logic [3:0]           ccb_cmpl_line_i,
  input  wire logic [$clog2(DEPTH)-1:0] ccb_cmpl_slot_i,
  input  wire logic [15:0]          ccb_cmpl_status_i,
  // table writes from the line side
  input  wire logic                 lct_we_i,
  input  wire logic [3:0]           lct_line_i,
  input  wire logic [5:0]           lct_idx_i,
  input  wire logic [7:0]           lct_data_i,
  // state
  output logic                      init_busy_o
);
  if (DEPTH < 2 || DEPTH > 64)
  begin
    $error("cphio_dev: DEPTH out of range");
  end

  typedef struct packed {
    logic                        rsp;
    logic                        acc;
    logic                        nak;
    logic [15:0]                 rd;
    logic                        irq;
    logic [3:0]                  irq_line;
    logic [7:0]                  init_cnt;
    logic                        busy;
    logic [15:0][63:0][7:0]      line_control_table;
  } cphio_dev_t;

  cphio_dev_t r_reg;
  cphio_dev_t r_next;

  logic [15:0] head_range;
  logic [15:0] head_status;
  logic [15:0] next_status;
  logic        next_valid;
  logic        adv;
  logic        ccb_irq;
  logic [3:0]  ccb_irq_line;
  logic [3:0]  line;
  logic [5:0]  fc;
  logic        hit;

  assign line = cphio_pkg::cfw_line(bus.cfw);
  assign fc   = cphio_pkg::cfw_fc(bus.cfw);
  assign hit  = bus.req && (cphio_pkg::cfw_bus(bus.cfw) == BUS_CHAN);

  cphio_ccb_list #(
    .DEPTH (DEPTH)
  ) u_list (
    .mclk_i        (mclk_i),
    .rst_n_i       (rst_n_i),
    .clear_i       (r_reg.busy),
    .sel_line_i    (line),
    .adv_i         (adv),
    .head_range_o  (head_range),
    .head_status_o (head_status),
    .next_status_o (next_status),
    .next_valid_o  (next_valid),
    .load_i        (ccb_load_i),
    .load_line_i   (ccb_load_line_i),
    .load_slot_i   (ccb_load_slot_i),
    .load_range_i  (ccb_load_range_i),
    .load_ien_i    (ccb_load_ien_i),
    .cmpl_i        (ccb_cmpl_i),
    .cmpl_line_i   (ccb_cmpl_line_i),
    .cmpl_slot_i   (ccb_cmpl_slot_i),
    .cmpl_status_i (ccb_cmpl_status_i),
    .irq_o         (ccb_irq),
    .irq_line_o    (ccb_irq_line)
  );

  always_comb
  begin
    logic [5:0] ind;
    // 64-byte table, only the low six index bits reach a byte
    ind = r_reg.line_control_table[line][cphio_pkg::LCT_INDEX][5:0];
    r_next = r_reg;
    adv = 1'b0;
    r_next.rsp = 1'b0;
    r_next.acc = 1'b0;
    r_next.nak = 1'b0;
    r_next.rd  = 16'h0000;
    r_next.irq = ccb_irq;
    r_next.irq_line = ccb_irq_line;
    if (r_reg.init_cnt != 8'h00)
      r_next.init_cnt = r_reg.init_cnt - 8'h01;
    if (init_req_i)
      r_next.init_cnt = cphio_pkg::INIT_CYCLES;
    if (lct_we_i)
      r_next.line_control_table[lct_line_i][lct_idx_i] = lct_data_i;
    if (hit)
    begin
      r_next.rsp = 1'b1;
      if (r_reg.busy)
        r_next.nak = 1'b1;
      else if (!adapter_present_i[line])
        r_next.nak = 1'b1;
      else
      begin
        r_next.acc = 1'b1;
        case (fc)
          cphio_pkg::FC_RANGE:
            r_next.rd = head_range;
          cphio_pkg::FC_STAT:
            r_next.rd = head_status;
          cphio_pkg::FC_LR5:
            r_next.rd = lr5_i[line];
          cphio_pkg::FC_ID:
            r_next.rd = adapter_id_i[line];
          cphio_pkg::FC_LCT_RD:
            r_next.rd = {8'h00, r_reg.line_control_table[line][ind]};
          cphio_pkg::FC_NEXT:
          begin
            if (!next_valid)
            begin
              r_next.acc = 1'b0;
              r_next.nak = 1'b1;
            end
            else
            begin
              adv = 1'b1;
              r_next.rd = next_status;
            end
          end
          cphio_pkg::FC_LCT_WR:
            r_next.line_control_table[line][bus.wr_opnd[13:8]] = bus.wr_opnd[7:0];
          default:
          begin
            r_next.acc = 1'b0;
            r_next.nak = 1'b1;
          end
        endcase
      end
    end
    r_next.busy = (r_next.init_cnt != 8'h00);
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      r_reg <= '0;
      r_reg.init_cnt <= cphio_pkg::INIT_CYCLES;
      r_reg.busy <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  assign bus.rsp      = r_reg.rsp;
  assign bus.acc      = r_reg.acc;
  assign bus.nak      = r_reg.nak;
  assign bus.rd_opnd  = r_reg.rd;
  assign bus.irq      = r_reg.irq;
  assign bus.irq_line = r_reg.irq_line;
  assign init_busy_o  = r_reg.busy;
endmodule
`default_nettype wire

// ===== core/cphio_host.sv
`timescale 1ns/1ps
`default_nettype none
module cphio_host (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic [1:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  // device side
  cphio_if.host            bus
);
  typedef struct packed {
    logic        req;
    logic [15:0] cfw;
    logic [15:0] opnd;
    logic [15:0] result;
    logic        busy;
    logic        acc;
    logic        nak;
    logic        tmo;
    logic        irq_seen;
    logic [3:0]  irq_line;
    logic [3:0]  tcnt;
    logic [15:0] rdata;
  } cphio_host_t;

  cphio_host_t r_reg;
  cphio_host_t r_next;

  always_comb
  begin
    r_next = r_reg;
    r_next.req = 1'b0;
    r_next.rdata = 16'h0000;
    if (r_reg.busy)
    begin
      if (bus.rsp)
      begin
        r_next.busy   = 1'b0;
        r_next.result = bus.rd_opnd;
        r_next.acc    = bus.acc;
        r_next.nak    = bus.nak;
      end
      else if (r_reg.tcnt == cphio_pkg::TMO_CYCLES - 4'h1)
      begin
        r_next.busy = 1'b0;
        r_next.tmo  = 1'b1;
      end
      else
        r_next.tcnt = r_reg.tcnt + 4'h1;
    end
    if (wr_i)
    begin
      case (addr_i)
        cphio_pkg::REG_OPND:
          r_next.opnd = wdata_i;
        cphio_pkg::REG_CMD:
          if (!r_reg.busy)
          begin
            r_next.cfw  = wdata_i;
            r_next.req  = 1'b1;
            r_next.busy = 1'b1;
            r_next.tcnt = 4'h0;
            r_next.acc  = 1'b0;
            r_next.nak  = 1'b0;
            r_next.tmo  = 1'b0;
          end
        cphio_pkg::REG_STATUS:
          if (wdata_i[cphio_pkg::ST_IRQ])
            r_next.irq_seen = 1'b0;
        default:
          r_next.opnd = r_reg.opnd;
      endcase
    end
    // new interrupt wins over a same-cycle clear
    if (bus.irq)
    begin
      r_next.irq_seen = 1'b1;
      r_next.irq_line = bus.irq_line;
    end
    if (rd_i)
    begin
      case (addr_i)
        cphio_pkg::REG_CMD:    r_next.rdata = r_reg.cfw;
        cphio_pkg::REG_OPND:   r_next.rdata = r_reg.opnd;
        cphio_pkg::REG_RESULT: r_next.rdata = r_reg.result;
        default:
          r_next.rdata = {4'h0, r_reg.irq_line, 3'h0, r_reg.irq_seen,
                          r_reg.tmo, r_reg.nak, r_reg.acc, r_reg.busy};
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign bus.req     = r_reg.req;
  assign bus.cfw     = r_reg.cfw;
  assign bus.wr_opnd = r_reg.opnd;
  assign rdata_o     = r_reg.rdata;
endmodule
`default_nettype wire

// ===== dv/cphio_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cphio_checker #(
  parameter logic [5:0] BUS_CHAN = 6'h00
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // host to device
  input  wire logic        req,
  input  wire logic [15:0] cfw,
  input  wire logic [15:0] wr_opnd,
  // device to host
  input  wire logic        rsp,
  input  wire logic        acc,
  input  wire logic        nak,
  input  wire logic [15:0] rd_opnd,
  input  wire logic        irq,
  input  wire logic [3:0]  irq_line
);
  logic [7:0] up_reg;
  logic [7:0] up_next;
  logic       own;
  logic       known;

  assign own   = cfw[15:10] == BUS_CHAN;
  assign known = cfw[5:0] inside {6'h0c, 6'h18, 6'h1a, 6'h1c, 6'h1e, 6'h26, 6'h0b};

  // cycles since reset release, saturating
  always_comb
  begin
    up_next = (up_reg == 8'hff) ? up_reg : up_reg + 8'h01;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      up_reg <= 8'h00;
    else
      up_reg <= up_next;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  property p_answer;
    req && own |=> rsp;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer one cycle after request");

  property p_cause;
    rsp |-> $past(req) && $past(own);
  endproperty
  a_cause: assert property (p_cause) else $error("answer without own request");

  property p_foreign;
    req && !own |=> !rsp [*8];
  endproperty
  a_foreign: assert property (p_foreign) else $error("answer to foreign bus channel");

  property p_excl;
    rsp |-> acc != nak;
  endproperty
  a_excl: assert property (p_excl) else $error("accept and refuse not exclusive");

  property p_pulse;
    rsp |=> !rsp && !acc && !nak;
  endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");

  property p_init;
    rsp && up_reg < 8'h0e |-> nak;
  endproperty
  a_init: assert property (p_init) else $error("accepted while initializing");

  property p_unimpl;
    req && own && !known |=> rsp && nak;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unknown code not refused");

  property p_idle;
    !rsp |-> rd_opnd == 16'h0000 && !acc && !nak;
  endproperty
  a_idle: assert property (p_idle) else $error("returned word outside answer");

  property p_irq;
    irq |=> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt pulse too long");

  property p_line;
    !irq |-> $stable(irq_line);
  endproperty
  a_line: assert property (p_line) else $error("interrupt line moved without pulse");
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [5:0] BUS = 6'h2a;
  logic              mclk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic [1:0]        addr = 2'h0;
  logic [15:0]       wdata = 16'h0000;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [15:0]       rdata;
  logic              init_req = 1'b0;
  logic [15:0]       present = 16'hffdf;
  logic [15:0][15:0] lr5;
  logic [15:0][15:0] aid;
  logic              ld = 1'b0;
  logic              cm = 1'b0;
  logic [1:0]        slot = 2'h0;
  logic [15:0]       val = 16'h0000;
  logic              ien = 1'b0;
  logic              lwe = 1'b0;
  logic [5:0]        lidx = 6'h00;
  logic [7:0]        ldat = 8'h00;
  logic              init_busy;
  logic [15:0]       st;
  logic [15:0]       rg [16];
  logic [15:0]       sv [16];
  logic [5:0]        bad [6] = '{6'h09, 6'h0f, 6'h00, 6'h3f, 6'h08, 6'h05};
  logic [17:0]       exp_q [$];
  logic [17:0]       e;
  int                n_fail = 0;
  int                check_count = 0;

  cphio_if bus_if ();
  cphio_dev #(.BUS_CHAN(BUS), .DEPTH(4)) cphio_dev_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(bus_if.dev), .init_req_i(init_req),
    .adapter_present_i(present), .lr5_i(lr5), .adapter_id_i(aid),
    .ccb_load_i(ld), .ccb_load_line_i(4'h3), .ccb_load_slot_i(slot), .ccb_load_range_i(val),
    .ccb_load_ien_i(ien), .ccb_cmpl_i(cm), .ccb_cmpl_line_i(4'h3), .ccb_cmpl_slot_i(slot),
    .ccb_cmpl_status_i(val), .lct_we_i(lwe), .lct_line_i(4'h3), .lct_idx_i(lidx),
    .lct_data_i(ldat), .init_busy_o(init_busy));
  cphio_host cphio_host_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .bus(bus_if.host));
  cphio_checker #(.BUS_CHAN(BUS)) cphio_checker_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .req(bus_if.req), .cfw(bus_if.cfw), .wr_opnd(bus_if.wr_opnd), .rsp(bus_if.rsp), .acc(bus_if.acc),
    .nak(bus_if.nak), .rd_opnd(bus_if.rd_opnd), .irq(bus_if.irq), .irq_line(bus_if.irq_line));

  always #2.5 mclk_i = ~mclk_i;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stall();
    check(16'h0001, 16'h0000);
    finish_test();
  endtask

  task automatic wreg(input logic [1:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic rreg(input logic [1:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge mclk_i);
  endtask

  // one instruction; x holds word check flag, nak and word
  task automatic op(input logic [5:0] b, input logic [3:0] l, input logic [5:0] f,
                    input logic [15:0] o, input logic [17:0] x);
    logic [15:0] res;
    if (b == BUS)
      exp_q.push_back(x);
    wreg(cphio_pkg::REG_OPND, o);
    wreg(cphio_pkg::REG_CMD, {b, l, f});
    st = 16'hffff;
    for (int i = 0; i < 20 && st[cphio_pkg::ST_BUSY] !== 1'b0; i++)
      rreg(cphio_pkg::REG_STATUS, st);
    if (st[cphio_pkg::ST_BUSY] !== 1'b0)
      stall();
    else if (b == BUS)
    begin
      check({14'h0000, st[cphio_pkg::ST_ACC], st[cphio_pkg::ST_NAK]}, {14'h0000, !x[16], x[16]});
      rreg(cphio_pkg::REG_RESULT, res);
      if (x[17])
        check(res, x[15:0]);
    end
  endtask

  task automatic ok(input logic [3:0] l, input logic [5:0] f, input logic [15:0] w);
    op(BUS, l, f, 16'h0000, {2'b10, w});
  endtask

  task automatic rej(input logic [3:0] l, input logic [5:0] f);
    op(BUS, l, f, 16'h0000, 18'h10000);
  endtask

  task automatic wlct(input logic [5:0] i, input logic [7:0] d);
    op(BUS, 4'h3, cphio_pkg::FC_LCT_WR, {2'b00, i, d}, 18'h00000);
  endtask

  // block setup or completion on line 3
  task automatic blk(input logic c, input logic [1:0] s, input logic [15:0] v, input logic ie);
    ld <= !c;
    cm <= c;
    slot <= s;
    val <= v;
    ien <= ie;
    @(posedge mclk_i);
    ld <= 1'b0;
    cm <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic wait_init();
    for (int i = 0; i < 40 && init_busy !== 1'b0; i++)
      @(posedge mclk_i);
    if (init_busy !== 1'b0)
      stall();
  endtask

  always @(negedge mclk_i)
  begin
    if (bus_if.rsp === 1'b1)
    begin
      if (exp_q.size() == 0)
        stall();
      else
      begin
        e = exp_q.pop_front();
        check({15'h0000, bus_if.nak}, {15'h0000, e[16]});
        if (e[17])
          check(bus_if.rd_opnd, e[15:0]);
      end
    end
  end

  initial
  begin
    void'($urandom(32'h7fbe6dcb));
    for (int i = 0; i < 16; i++)
    begin
      lr5[i] = 16'($urandom());
      aid[i] = 16'($urandom());
      rg[i] = 16'($urandom());
      sv[i] = 16'($urandom()) | 16'h8000;
    end
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    rej(4'h3, cphio_pkg::FC_STAT);
    wait_init();
    $display("test init refusal done");
    for (int i = 0; i < 4; i++)
      blk(1'b0, i[1:0], rg[i], i == 0);
    ok(4'h3, cphio_pkg::FC_RANGE, rg[0]);
    ok(4'h3, cphio_pkg::FC_STAT, 16'h0000);
    blk(1'b1, 2'h0, sv[0], 1'b0);
    ok(4'h3, cphio_pkg::FC_STAT, sv[0]);
    check(st & 16'h0f10, 16'h0310);
    wreg(cphio_pkg::REG_STATUS, 16'h0010);
    ok(4'h3, cphio_pkg::FC_STAT, sv[0]);
    ok(4'h3, cphio_pkg::FC_NEXT, 16'h0000);
    ok(4'h3, cphio_pkg::FC_RANGE, rg[1]);
    blk(1'b1, 2'h2, sv[2], 1'b0);
    ok(4'h3, cphio_pkg::FC_NEXT, sv[2]);
    check(st & 16'h0010, 16'h0000);
    ok(4'h3, cphio_pkg::FC_STAT, sv[2]);
    ok(4'h3, cphio_pkg::FC_NEXT, 16'h0000);
    rej(4'h3, cphio_pkg::FC_NEXT);
    blk(1'b0, 2'h0, rg[4], 1'b0);
    ok(4'h3, cphio_pkg::FC_NEXT, 16'h0000);
    ok(4'h3, cphio_pkg::FC_RANGE, rg[4]);
    $display("test block list done");
    for (int l = 0; l < 16; l++)
      if (present[l])
      begin
        ok(l[3:0], cphio_pkg::FC_LR5, lr5[l]);
        ok(l[3:0], cphio_pkg::FC_ID, aid[l]);
      end
      else
        rej(l[3:0], cphio_pkg::FC_ID);
    op(BUS ^ 6'h01, 4'h3, cphio_pkg::FC_STAT, 16'h0000, 18'h00000);
    check({15'h0000, st[cphio_pkg::ST_TMO]}, 16'h0001);
    $display("test line decode done");
    wlct(cphio_pkg::LCT_INDEX, 8'h21);
    wlct(6'h21, rg[5][7:0]);
    ok(4'h3, cphio_pkg::FC_LCT_RD, {8'h00, rg[5][7:0]});
    lidx <= 6'h30;
    ldat <= rg[6][7:0];
    lwe <= 1'b1;
    @(posedge mclk_i);
    lwe <= 1'b0;
    wlct(cphio_pkg::LCT_INDEX, 8'h30);
    ok(4'h3, cphio_pkg::FC_LCT_RD, {8'h00, rg[6][7:0]});
    $display("test table read done");
    for (int i = 0; i < 6; i++)
      rej(4'h3, bad[i]);
    rej(4'h3, 6'h05);
    ok(4'h3, cphio_pkg::FC_STAT, 16'h0000);
    $display("test unknown codes done");
    init_req <= 1'b1;
    @(posedge mclk_i);
    init_req <= 1'b0;
    rej(4'h3, cphio_pkg::FC_STAT);
    wait_init();
    check(16'(exp_q.size()), 16'h0000);
    $display("test restart done");
    finish_test();
  end
endmodule
`default_nettype wire
